//--- design/tmscr_pkg.sv
package tmscr_pkg;
  // oscillator rate and indicator blink timing
  localparam int unsigned clk_hz = 10_000_000;
  localparam int unsigned ptp_blink_ms = 2000;
  localparam int unsigned act_blink_ms = 100;
  localparam int unsigned ptp_half_cyc = clk_hz / 1000 * ptp_blink_ms / 2;
  localparam int unsigned act_half_cyc = clk_hz / 1000 * act_blink_ms / 2;

  // register byte offsets
  localparam int addr_w = 8;
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] gps_off = 8'h04;
  localparam logic [7:0] ptp_off = 8'h08;
  localparam logic [7:0] pfi_dir_off = 8'h0c;
  localparam logic [7:0] pfi_out_off = 8'h10;
  localparam logic [7:0] trig_oe_off = 8'h14;
  localparam logic [7:0] trig_out_off = 8'h18;
  localparam logic [7:0] star_oe_off = 8'h1c;
  localparam logic [7:0] star_out_off = 8'h20;
  localparam logic [7:0] status_off = 8'h24;
  localparam logic [7:0] irq_stat_off = 8'h28;
  localparam logic [7:0] irq_mask_off = 8'h2c;

  // line counts
  localparam int pfi_n = 3;
  localparam int trig_n = 8;
  localparam int star_n = 13;

  // satellite receiver state codes
  localparam logic [1:0] gps_starting = 2'h0;
  localparam logic [1:0] gps_survey = 2'h1;
  localparam logic [1:0] gps_done = 2'h2;

  // time protocol port state codes
  localparam logic [3:0] ptp_disabled = 4'h0;
  localparam logic [3:0] ptp_init = 4'h1;
  localparam logic [3:0] ptp_listen = 4'h2;
  localparam logic [3:0] ptp_passive = 4'h3;
  localparam logic [3:0] ptp_uncal = 4'h4;
  localparam logic [3:0] ptp_slave = 4'h5;
  localparam logic [3:0] ptp_master = 4'h6;
  localparam logic [3:0] ptp_premaster = 4'h7;
  localparam logic [3:0] ptp_faulty = 4'h8;

  // interrupt event bit positions
  localparam int irq_w = 3;
  localparam int ev_gps_fault = 0;
  localparam int ev_link = 1;
  localparam int ev_refused = 2;

  // control register layout, lsb is gps_ref
  typedef struct packed {
    logic irig_am;
    logic irig_en;
    logic ptp_en;
    logic repl_en;
    logic repl_src;
    logic clock_output_connector_src;
    logic gps_ref;
  } tmscr_ctrl_type;
  localparam int ctrl_w = $bits(tmscr_ctrl_type);
  localparam tmscr_ctrl_type ctrl_rst = '0;

  // sampled status pins, lsb is ant_open
  typedef struct packed {
    logic [7:0] trig;
    logic [2:0] pfi;
    logic slot2;
    logic activity;
    logic speed100;
    logic link;
    logic hw_fault;
    logic ant_fault;
    logic ant_open;
  } tmscr_stat_type;

  // one indicator, amber is both
  typedef struct packed {
    logic red;
    logic green;
  } tmscr_led_type;
  localparam tmscr_led_type led_off = 2'h0;
  localparam tmscr_led_type led_green = 2'h1;
  localparam tmscr_led_type led_red = 2'h2;
  localparam tmscr_led_type led_amber = 2'h3;
endpackage

//--- design/tmscr_top.sv
`timescale 1ns/10ps
module tmscr_top
  import tmscr_pkg::*;
#(
  parameter int unsigned ptp_half_cycles = ptp_half_cyc,
  parameter int unsigned act_half_cycles = act_half_cyc
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [addr_w-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic irq,
  // asynchronous status pins
  input wire tmscr_stat_type stat_pins,
  // clocks
  input wire logic backplane_clk10,
  input wire logic clock_input_connector,
  output logic clock_output_connector,
  output logic clk10_in_o,
  output logic clk10_in_oe,
  // indicators
  output tmscr_led_type gps_led,
  output tmscr_led_type ptp_led,
  output tmscr_led_type speed_led,
  output tmscr_led_type link_activity_indicator,
  // function lines and time code
  output logic [pfi_n-1:0] programmable_function_lines_o,
  output logic [pfi_n-1:0] programmable_function_lines_oe,
  output logic time_code_dc,
  output logic irig_am_sel,
  // backplane triggers
  output logic [trig_n-1:0] trig_o,
  output logic [trig_n-1:0] trig_oe,
  output logic [star_n-1:0] star_o,
  output logic [star_n-1:0] star_oe
);
  localparam int unsigned max_half = (ptp_half_cycles > act_half_cycles) ?
    ptp_half_cycles : act_half_cycles;
  localparam int cnt_w = $clog2(max_half + 1);
  localparam logic [cnt_w-1:0] slow_top = cnt_w'(ptp_half_cycles - 1);
  localparam logic [cnt_w-1:0] fast_top = cnt_w'(act_half_cycles - 1);

  typedef struct packed {
    tmscr_ctrl_type ctrl;
    logic [1:0] gps_code;
    logic [3:0] ptp_code;
    logic [pfi_n-1:0] pfi_dir;
    logic [pfi_n-1:0] pfi_out;
    logic [trig_n-1:0] trig_en;
    logic [trig_n-1:0] trig_out;
    logic [star_n-1:0] star_en;
    logic [star_n-1:0] star_out;
    logic [irq_w-1:0] irq_stat;
    logic [irq_w-1:0] irq_mask;
    tmscr_stat_type sync1;
    tmscr_stat_type sync2;
    tmscr_stat_type prev;
    logic [cnt_w-1:0] slow_cnt;
    logic [cnt_w-1:0] fast_cnt;
    logic slow_ph;
    logic fast_ph;
    logic act_seen;
    logic act_blink;
    tmscr_led_type gps_led;
    tmscr_led_type ptp_led;
    tmscr_led_type spd_led;
    tmscr_led_type act_led;
    logic [pfi_n-1:0] pfi_en;
    logic [star_n-1:0] star_drv;
    logic repl_oe;
    logic tcode;
    logic [31:0] rdata;
    logic err;
  } tmscr_state_type;

  tmscr_state_type state_reg;
  tmscr_state_type state_next;
  tmscr_stat_type st;
  tmscr_ctrl_type wctrl;
  logic wr;
  logic setup;
  logic gps_fault;
  logic [irq_w-1:0] ev;
  logic [irq_w-1:0] clr;

  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign prdata = state_reg.rdata;
  assign pslverr = state_reg.err;
  assign irq = |(state_reg.irq_stat & state_reg.irq_mask);

  // clock routing is a plain mux; no glitch-free switch, change when idle
  assign clock_output_connector = state_reg.ctrl.clock_output_connector_src ?
    backplane_clk10 : pclk;
  assign clk10_in_o = state_reg.ctrl.repl_src ?
    clock_input_connector : pclk;
  assign clk10_in_oe = state_reg.repl_oe;

  // outputs straight from state flops
  assign gps_led = state_reg.gps_led;
  assign ptp_led = state_reg.ptp_led;
  assign speed_led = state_reg.spd_led;
  assign link_activity_indicator = state_reg.act_led;
  assign programmable_function_lines_o = state_reg.pfi_out;
  assign programmable_function_lines_oe = state_reg.pfi_en;
  assign time_code_dc = state_reg.tcode;
  assign irig_am_sel = state_reg.ctrl.irig_am;
  assign trig_o = state_reg.trig_out;
  assign trig_oe = state_reg.trig_en;
  assign star_o = state_reg.star_out;
  assign star_oe = state_reg.star_drv;

  // bus decode and event sources
  assign st = state_reg.sync2;
  assign wr = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign wctrl = tmscr_ctrl_type'(pwdata[ctrl_w-1:0]);
  assign gps_fault = st.ant_open | st.ant_fault | st.hw_fault;
  assign clr = (wr && paddr == irq_stat_off) ? pwdata[irq_w-1:0] : '0;

  always_comb
  begin
    ev = '0;
    ev[ev_gps_fault] = gps_fault & ~(state_reg.prev.ant_open |
      state_reg.prev.ant_fault | state_reg.prev.hw_fault);
    ev[ev_link] = st.link ^ state_reg.prev.link;
    ev[ev_refused] = wr && paddr == ctrl_off && wctrl.repl_en && !st.slot2;
  end

  // next state
  always_comb
  begin
    state_next = state_reg;
    // two-flop synchroniser for every pin
    state_next.sync1 = stat_pins;
    state_next.sync2 = state_reg.sync1;
    state_next.prev = st;
    // register writes in the access phase
    if (wr)
    begin
      case (paddr)
        ctrl_off: state_next.ctrl = wctrl;
        gps_off: state_next.gps_code = pwdata[1:0];
        ptp_off: state_next.ptp_code = pwdata[3:0];
        pfi_dir_off: state_next.pfi_dir = pwdata[pfi_n-1:0];
        pfi_out_off: state_next.pfi_out = pwdata[pfi_n-1:0];
        trig_oe_off: state_next.trig_en = pwdata[trig_n-1:0];
        trig_out_off: state_next.trig_out = pwdata[trig_n-1:0];
        star_oe_off: state_next.star_en = pwdata[star_n-1:0];
        star_out_off: state_next.star_out = pwdata[star_n-1:0];
        irq_mask_off: state_next.irq_mask = pwdata[irq_w-1:0];
        default: state_next.err = state_reg.err;
      endcase
    end
    // sticky events, a new event beats a same-cycle clear
    state_next.irq_stat = (state_reg.irq_stat & ~clr) | ev;
    // read data and error prepared in setup for the access phase
    if (setup)
    begin
      state_next.err = 1'b0;
      case (paddr)
        ctrl_off: state_next.rdata = 32'(state_reg.ctrl);
        gps_off: state_next.rdata = 32'(state_reg.gps_code);
        ptp_off: state_next.rdata = 32'(state_reg.ptp_code);
        pfi_dir_off: state_next.rdata = 32'(state_reg.pfi_dir);
        pfi_out_off: state_next.rdata = 32'(state_reg.pfi_out);
        trig_oe_off: state_next.rdata = 32'(state_reg.trig_en);
        trig_out_off: state_next.rdata = 32'(state_reg.trig_out);
        star_oe_off: state_next.rdata = 32'(state_reg.star_en);
        star_out_off: state_next.rdata = 32'(state_reg.star_out);
        status_off: state_next.rdata = 32'(st);
        irq_stat_off: state_next.rdata = 32'(state_reg.irq_stat);
        irq_mask_off: state_next.rdata = 32'(state_reg.irq_mask);
        default:
        begin
          state_next.rdata = '0;
          state_next.err = 1'b1;
        end
      endcase
    end
    // slow blink, one half-period per phase
    if (state_reg.slow_cnt == slow_top)
    begin
      state_next.slow_cnt = '0;
      state_next.slow_ph = ~state_reg.slow_ph;
    end
    else
    begin
      state_next.slow_cnt = state_reg.slow_cnt + 1'b1;
    end
    // traffic blink; a single packet gives a visible blink only when it lands while fast_ph is low
    state_next.act_seen = state_reg.act_seen | st.activity;
    if (state_reg.fast_cnt == fast_top)
    begin
      state_next.fast_cnt = '0;
      state_next.fast_ph = ~state_reg.fast_ph;
      state_next.act_blink = state_reg.act_seen | st.activity;
      state_next.act_seen = st.activity;
    end
    else
    begin
      state_next.fast_cnt = state_reg.fast_cnt + 1'b1;
    end
    // satellite receiver indicator
    if (!state_reg.ctrl.gps_ref)
    begin
      state_next.gps_led = led_off;
    end
    else if (gps_fault)
    begin
      state_next.gps_led = led_red;
    end
    else
    begin
      case (state_reg.gps_code)
        gps_starting: state_next.gps_led = led_amber;
        gps_survey:
          state_next.gps_led = state_reg.slow_ph ? led_amber : led_off;
        gps_done:
          state_next.gps_led = state_reg.slow_ph ? led_green : led_off;
        default: state_next.gps_led = led_off;
      endcase
    end
    // time protocol indicator
    if (!state_reg.ctrl.ptp_en)
    begin
      state_next.ptp_led = led_off;
    end
    else
    begin
      case (state_reg.ptp_code)
        ptp_init: state_next.ptp_led = led_amber;
        ptp_listen, ptp_passive:
          state_next.ptp_led = state_reg.slow_ph ? led_amber : led_off;
        ptp_uncal, ptp_slave: state_next.ptp_led = led_green;
        ptp_master, ptp_premaster:
          state_next.ptp_led = state_reg.slow_ph ? led_green : led_off;
        ptp_faulty: state_next.ptp_led = led_red;
        default: state_next.ptp_led = led_off;
      endcase
    end
    // link speed and activity indicators
    state_next.spd_led = (st.link && st.speed100) ?
      led_green : led_off;
    if (!st.link)
    begin
      state_next.act_led = led_off;
    end
    else if (state_reg.act_blink && state_reg.fast_ph)
    begin
      state_next.act_led = led_off;
    end
    else
    begin
      state_next.act_led = led_green;
    end
    // pin drivers; a time code input on line zero is never driven
    state_next.pfi_en = state_reg.pfi_dir;
    if (state_reg.ctrl.irig_en || state_reg.ctrl.irig_am)
    begin
      state_next.pfi_en[0] = 1'b0;
    end
    state_next.tcode = state_reg.ctrl.irig_en && !state_reg.ctrl.irig_am &&
      st.pfi[0];
    state_next.star_drv = st.slot2 ? state_reg.star_en : '0;
    state_next.repl_oe = state_reg.ctrl.repl_en && st.slot2;
  end

  // one register for all state; reset puts indicators and drivers off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  gps_dark_a: assert property (
    !state_reg.ctrl.gps_ref |=> gps_led == led_off)
    else $error("satellite indicator lit while not time reference");

  gps_red_a: assert property (
    state_reg.ctrl.gps_ref && gps_fault |=> gps_led == led_red)
    else $error("satellite fault not shown red");

  gps_survey_a: assert property (
    state_reg.ctrl.gps_ref && !gps_fault && state_reg.gps_code == gps_survey
    |=> gps_led == led_amber || gps_led == led_off)
    else $error("survey indicator not amber or dark");

  ptp_init_a: assert property (
    state_reg.ctrl.ptp_en && state_reg.ptp_code == ptp_init
    |=> ptp_led == led_amber)
    else $error("initializing protocol not steady amber");

  ptp_listen_a: assert property (
    state_reg.ctrl.ptp_en && state_reg.ptp_code == ptp_listen &&
    state_reg.slow_cnt == slow_top
    ##1 state_reg.ctrl.ptp_en && state_reg.ptp_code == ptp_listen
    |=> ptp_led != $past(ptp_led))
    else $error("listening indicator did not toggle at half period");

  speed_led_a: assert property (
    ##1 speed_led == (($past(st.link) && $past(st.speed100)) ?
    led_green : led_off))
    else $error("speed indicator wrong for link state");

  act_off_a: assert property (
    !st.link |=> link_activity_indicator == led_off)
    else $error("activity indicator lit with no link");

  repl_gate_a: assert property (
    !(state_reg.ctrl.repl_en && st.slot2) |=> !clk10_in_oe)
    else $error("replacement clock driven when not allowed");

  star_gate_a: assert property (
    !st.slot2 |=> star_oe == '0)
    else $error("star lines driven outside slot two");

  pfi_zero_a: assert property (
    state_reg.ctrl.irig_en |=> !programmable_function_lines_oe[0])
    else $error("line zero driven while time code input");

  irq_sticky_a: assert property (
    state_reg.irq_stat[ev_link] && !clr[ev_link]
    |=> state_reg.irq_stat[ev_link])
    else $error("sticky event bit lost without clear");

  ptp_red_a: assert property (
    state_reg.ctrl.ptp_en && state_reg.ptp_code == ptp_faulty
    |=> ptp_led == led_red)
    else $error("faulty protocol port not shown red");

  pfi_dir_a: assert property (
    !state_reg.pfi_dir[1] |=> !programmable_function_lines_oe[1])
    else $error("function line driven while set as input");
endmodule

//--- dv/tmscr_chassis.sv
`timescale 1ns/10ps
module tmscr_chassis
  import tmscr_pkg::*;
(
  // replacement clock offered by the module
  input wire logic clk10_in_o,
  input wire logic clk10_in_oe,
  // shared trigger lines, module and peer drivers
  input wire logic [trig_n-1:0] trig_o,
  input wire logic [trig_n-1:0] trig_oe,
  input wire logic [trig_n-1:0] peer_o,
  input wire logic [trig_n-1:0] peer_oe,
  output logic [trig_n-1:0] trig_bus,
  // backplane reference clock
  output logic backplane_clk10
);
  logic native_clk;

  // native oscillator, phase unrelated to the module clock
  initial
  begin
    native_clk = 1'b0;
    #31;
    forever #50 native_clk = ~native_clk;
  end

  // slot 2 module takes over the reference only while it drives
  assign backplane_clk10 = clk10_in_oe ? clk10_in_o : native_clk;

  // undriven lines float up to the pull-up level
  always_comb
    for (int i = 0; i < trig_n; i++)
      trig_bus[i] = trig_oe[i] ? trig_o[i] : peer_oe[i] ? peer_o[i] : 1'b1;
endmodule

//--- dv/testbench.sv
`timescale 1ns/10ps
module testbench
  import tmscr_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  tmscr_stat_type sp, stat_pins;
  logic backplane_clk10, clock_input_connector, clock_output_connector;
  logic clk10_in_o, clk10_in_oe, time_code_dc, irig_am_sel;
  tmscr_led_type gps_led, ptp_led, speed_led, act_led;
  logic [pfi_n-1:0] pfi_o, pfi_oe;
  logic [trig_n-1:0] trig_o, trig_oe, trig_bus, peer_o, peer_oe;
  logic [star_n-1:0] star_o, star_oe;
  int n_mismatch, cmp_count, cyc;
  // expected protocol indicator per state code, blink flags by code
  localparam tmscr_led_type pc [9] = '{led_off, led_amber, led_amber,
    led_amber, led_green, led_green, led_green, led_green, led_red};
  localparam logic [8:0] pb = 9'h0cc;

  tmscr_top #(.ptp_half_cycles(8), .act_half_cycles(4)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq), .stat_pins(stat_pins),
    .backplane_clk10(backplane_clk10),
    .clock_input_connector(clock_input_connector),
    .clock_output_connector(clock_output_connector),
    .clk10_in_o(clk10_in_o), .clk10_in_oe(clk10_in_oe),
    .gps_led(gps_led), .ptp_led(ptp_led), .speed_led(speed_led),
    .link_activity_indicator(act_led),
    .programmable_function_lines_o(pfi_o),
    .programmable_function_lines_oe(pfi_oe),
    .time_code_dc(time_code_dc), .irig_am_sel(irig_am_sel),
    .trig_o(trig_o), .trig_oe(trig_oe), .star_o(star_o), .star_oe(star_oe));

  tmscr_chassis chassis (.clk10_in_o(clk10_in_o),
    .clk10_in_oe(clk10_in_oe), .trig_o(trig_o), .trig_oe(trig_oe),
    .peer_o(peer_o), .peer_oe(peer_oe), .trig_bus(trig_bus),
    .backplane_clk10(backplane_clk10));

  // pins seen by the module: driven function lines read back their own level
  always_comb
  begin
    stat_pins = sp;
    stat_pins.trig = trig_bus;
    for (int i = 0; i < pfi_n; i++)
      stat_pins.pfi[i] = pfi_oe[i] ? pfi_o[i] : sp.pfi[i];
  end

  // module clock and an unrelated external clock input
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    clock_input_connector = 1'b0;
    #23;
    forever #50 clock_input_connector = ~clock_input_connector;
  end

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // the whole run needs about 1200 cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, entered and left just after a rising edge
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the bench timeout ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] e, input string what);
    xfer(a, 1'b0, 32'h0);
    check(rd, e, what);
    check(err, 1'b0, what);
  endtask

  task wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask

  function automatic tmscr_led_type pick(input int k);
    case (k)
      0: return gps_led;
      1: return ptp_led;
      2: return speed_led;
      default: return act_led;
    endcase
  endfunction

  // watch an indicator over two slow blink periods, at falling edges
  task led_watch(input int k, input tmscr_led_type col, input bit blink,
    input string what);
    int on, off, bad;
    on = 0;
    off = 0;
    bad = 0;
    wait_n(4);
    repeat (36)
    begin
      @(negedge pclk);
      if (pick(k) === col)
        on++;
      else if (pick(k) === led_off)
        off++;
      else
        bad++;
    end
    check(bad == 0 && (blink ? off > 0 && on > 0 : off == 0), 1'b1, what);
    @(posedge pclk);
  endtask

  task t_reset;
    check({gps_led, ptp_led, speed_led, act_led}, 8'h0, "leds");
    check(clk10_in_oe, 1'b0, "repl oe");
    check(pfi_oe, 3'h0, "pfi oe");
    check(irq, 1'b0, "irq");
    rdchk(ctrl_off, 32'h0, "ctrl");
    wr(pfi_out_off, 32'hffff_fffe);
    rdchk(pfi_out_off, 32'h6, "pfi out");
    wr(pfi_out_off, 32'h0);
    wr(status_off, 32'hffff_ffff);
    rdchk(status_off, 32'h3fc00, "status");
    xfer(8'h40, 1'b0, 32'h0);
    check(err, 1'b1, "unmapped err");
    check(rd, 32'h0, "unmapped data");
  endtask

  task t_gps;
    sp.ant_open <= 1'b1;
    led_watch(0, led_off, 0, "gps unused");
    sp.ant_open <= 1'b0;
    wr(irq_stat_off, 32'h7);
    wr(ctrl_off, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(gps_off, i);
      led_watch(0, i == 2 ? led_green : (i == 3 ? led_off : led_amber),
        i == 1 || i == 2, "gps");
    end
    wr(irq_mask_off, 32'h1);
    for (int b = 0; b < 3; b++)
    begin
      sp[b] <= 1'b1;
      led_watch(0, led_red, 0, "gps fault");
      check(irq, 1'b1, "irq raised");
      sp[b] <= 1'b0;
      wr(irq_stat_off, 32'h1);
      check(irq, 1'b0, "irq cleared");
    end
    wr(irq_mask_off, 32'h0);
    sp.hw_fault <= 1'b1;
    wait_n(4);
    check(irq, 1'b0, "irq masked");
    rdchk(irq_stat_off, 32'h1, "irq stat");
    sp.hw_fault <= 1'b0;
    wr(irq_stat_off, 32'h1);
  endtask

  task t_ptp;
    wr(ctrl_off, 32'h0);
    wr(ptp_off, 32'h5);
    led_watch(1, led_off, 0, "ptp stopped");
    wr(ctrl_off, 32'h10);
    for (int i = 0; i < 9; i++)
    begin
      wr(ptp_off, i);
      led_watch(1, pc[i], pb[i], "ptp");
    end
  endtask

  task t_eth;
    sp.speed100 <= 1'b1;
    led_watch(2, led_off, 0, "speed nolink");
    led_watch(3, led_off, 0, "act nolink");
    sp.link <= 1'b1;
    led_watch(2, led_green, 0, "speed 100");
    led_watch(3, led_green, 0, "link_activity_indicator");
    rdchk(irq_stat_off, 32'h2, "link event");
    sp.speed100 <= 1'b0;
    led_watch(2, led_off, 0, "speed 10");
    sp.activity <= 1'b1;
    led_watch(3, led_green, 1, "act traffic");
    sp.activity <= 1'b0;
    sp.link <= 1'b0;
    wait_n(4);
    wr(irq_stat_off, 32'h7);
  endtask

  // clock muxes checked between edges, away from any clock transition
  task clk_cmp(input bit co, input bit ri);
    wr(ctrl_off, {29'h0, ri, co, 1'b0});
    repeat (12)
    begin
      #17;
      check(clock_output_connector, co ? backplane_clk10 : pclk, "clock_output_connector");
      check(clk10_in_o, ri ? clock_input_connector : pclk, "repl src");
    end
    @(posedge pclk);
  endtask

  task t_repl;
    sp.slot2 <= 1'b1;
    for (int i = 0; i < 4; i++)
      clk_cmp(i[0], i[1]);
    check(clk10_in_oe, 1'b0, "repl idle");
    sp.slot2 <= 1'b0;
    // let the slot pin pass the synchroniser before the refused write
    wait_n(2);
    wr(ctrl_off, 32'h8);
    wait_n(4);
    check(clk10_in_oe, 1'b0, "repl slot");
    rdchk(irq_stat_off, 32'h4, "refused");
    wr(irq_mask_off, 32'h4);
    check(irq, 1'b1, "irq refused");
    wr(irq_stat_off, 32'h4);
    check(irq, 1'b0, "irq clear");
    sp.slot2 <= 1'b1;
    wait_n(4);
    check(clk10_in_oe, 1'b1, "repl on");
    wr(ctrl_off, 32'h0);
    wait_n(2);
    check(clk10_in_oe, 1'b0, "repl off");
    wr(irq_mask_off, 32'h0);
  endtask

  task t_pfi;
    wr(pfi_dir_off, 32'h5);
    wr(pfi_out_off, 32'h7);
    wait_n(2);
    check(pfi_oe, 3'h5, "pfi dir");
    check(pfi_o & pfi_oe, 3'h5, "pfi out");
    wr(pfi_dir_off, 32'h2);
    wait_n(2);
    check(pfi_oe, 3'h2, "pfi dir");
    wr(pfi_dir_off, 32'h7);
    wr(ctrl_off, 32'h20);
    sp.pfi <= 3'h1;
    wait_n(4);
    check(pfi_oe, 3'h6, "line0 code");
    check(time_code_dc, 1'b1, "code high");
    sp.pfi <= 3'h0;
    wait_n(4);
    check(time_code_dc, 1'b0, "code low");
    wr(ctrl_off, 32'h60);
    wait_n(2);
    check({irig_am_sel, pfi_oe[0]}, 2'h2, "am mode");
    wr(ctrl_off, 32'h0);
    wr(pfi_dir_off, 32'h0);
  endtask

  task t_trig;
    peer_oe <= 8'h02;
    peer_o <= 8'h00;
    wr(trig_oe_off, 32'ha5);
    wr(trig_out_off, 32'h0f);
    wr(star_oe_off, 32'h1fff);
    wr(star_out_off, 32'h0abc);
    wait_n(4);
    check(trig_oe, 8'ha5, "trig oe");
    check(trig_o & trig_oe, 8'h05, "trig out");
    rdchk(status_off, 32'h17440, "trig in");
    check(star_oe, 13'h1fff, "star oe");
    check(star_o, 13'h0abc, "star out");
    sp.slot2 <= 1'b0;
    wait_n(4);
    check(star_oe, 13'h0, "star slot");
    peer_oe <= 8'h00;
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sp = '0;
    peer_o = 8'h00;
    peer_oe = 8'h00;
    n_mismatch = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_gps();
    t_ptp();
    t_eth();
    t_repl();
    t_pfi();
    t_trig();
    report_and_stop();
  end
endmodule
